// *** design/conv_zone_opts.sv ***
// Per-zone jam handling, accumulate and release range options
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps

// Overview of operation
// - Separate option flags for upstream and downstream zone
// - Skip flag clears jam without auto-clear delay
// - Skip flag keeps jam detection active
// - Sensor jam gets up to three clear attempts
// - Disable flag: no attempts, hold until cleared
// - External clear request attempts sensor jam clear
// - Discharge waits jam time, else arrival jam
// - Arrival timeout disabled: never an arrival jam
// - Timeout disabled: admit upstream once carton left
// - Accumulate on external request or pin 3
// - Removed accumulated carton makes downstream zone search
// - Manual disable flag stops that search run
// - Range bounded by control and termination flags
// - Control zone pin 3 switches range mode
// - Energized pin inverts the default release mode
// - Accumulate setting restored from non-volatile store
// - Pin released: range returns to default mode
module conv_zone_opts #(
   parameter int JAM_CYC = conv_zone_pkg::JAM_CYC_DEF,
   parameter int CLEAR_CYC = conv_zone_pkg::CLEAR_CYC_DEF
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [3:0] WB_SEL_I,
   output logic WB_ACK_O,
   output logic [31:0] WB_DAT_O,
   input wire logic [1:0] DEPART,
   input wire logic [1:0] ARRIVE,
   input wire logic [1:0] SENSOR_JAM,
   input wire logic [1:0] ACC_REQ,
   input wire logic [1:0] PIN3,
   input wire logic [1:0] REMOVED,
   input wire logic [1:0] CLEAR_REQ,
   input wire logic RANGE_IN,
   input wire logic [1:0] NVM_ACCUM,
   output logic [1:0] ARR_JAM,
   output logic [1:0] SEN_JAM,
   output logic [1:0] CLEAR_RUN,
   output logic [1:0] ADMIT,
   output logic [1:0] SEARCH,
   output logic [1:0] TRAIN_MODE,
   output logic [1:0] ACCUMULATED,
   output logic RANGE_OUT,
   output logic NVM_SAVE,
   output logic [1:0] NVM_DATA,
   output logic IRQ
);
   // ------------------------------------------------------------
   // Widths and state
   // ------------------------------------------------------------
   localparam int ZN = conv_zone_pkg::ZONES;
   localparam int MAXC = (JAM_CYC > CLEAR_CYC) ? JAM_CYC : CLEAR_CYC;
   localparam int CNT_W = $clog2(MAXC + 1);
   localparam int IRQ_W = ZN * conv_zone_pkg::EV_W;
   localparam logic [CNT_W-1:0] JAM_LOAD = CNT_W'(JAM_CYC - 1);
   localparam logic [CNT_W-1:0] CLR_LOAD = CNT_W'(CLEAR_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;

   typedef struct packed {
      logic [conv_zone_pkg::SYNC_W-1:0] sync1;
      logic [conv_zone_pkg::SYNC_W-1:0] sync2;
      logic [conv_zone_pkg::SYNC_W-1:0] sync3;
      logic [1:0] start_cnt;
      logic [ZN-1:0][conv_zone_pkg::OPT_W-1:0] opt;
      logic [IRQ_W-1:0] ist;
      logic [IRQ_W-1:0] imask;
      conv_zone_pkg::arr_type [ZN-1:0] ar;
      conv_zone_pkg::sj_type [ZN-1:0] sj;
      logic [ZN-1:0][CNT_W-1:0] ar_cnt;
      logic [ZN-1:0][CNT_W-1:0] sj_cnt;
      logic [ZN-1:0][1:0] att;
      logic [ZN-1:0] arr_jam;
      logic [ZN-1:0] sen_jam;
      logic [ZN-1:0] clr_run;
      logic [ZN-1:0] admit;
      logic [ZN-1:0] search;
      logic [ZN-1:0] train;
      logic [ZN-1:0] acc;
      logic range_out;
      logic nvm_save;
      logic irq;
      logic ack;
      logic [31:0] dat;
   } st_type;

   st_type r;
   st_type n;

   // Byte lane merge for register writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic act;
      logic pass;
      logic acc_in;
      logic access;
      logic [31:0] merged;
      logic [IRQ_W-1:0] ev;
      logic [ZN-1:0] dep_e;
      logic [ZN-1:0] arr_s;
      logic [ZN-1:0] sj_s;
      logic [ZN-1:0] rem_e;
      logic [ZN-1:0] clr_e;
      logic [ZN-1:0] pin_s;
      logic [ZN-1:0] accq_s;
      logic [conv_zone_pkg::OPT_W-1:0] o;
      n = r;
      act = 1'b0;
      pass = r.sync2[conv_zone_pkg::IN_RNG];
      acc_in = 1'b0;
      merged = 32'h0000_0000;
      ev = '0;
      dep_e = '0;
      arr_s = '0;
      sj_s = '0;
      rem_e = '0;
      clr_e = '0;
      pin_s = '0;
      accq_s = '0;
      o = '0;
      access = WB_CYC_I & WB_STB_I & ~r.ack;
      // Two-stage synchronisers, third stage for edges
      n.sync1 = {NVM_ACCUM, RANGE_IN, CLEAR_REQ, REMOVED, PIN3, ACC_REQ,
         SENSOR_JAM, ARRIVE, DEPART};
      n.sync2 = r.sync1;
      n.sync3 = r.sync2;
      n.clr_run = '0;
      n.admit = '0;
      n.search = '0;
      n.nvm_save = 1'b0;
      for (int i = 0; i < ZN; i++) begin
         dep_e[i] = r.sync2[conv_zone_pkg::IN_DEP*ZN + i] &
            ~r.sync3[conv_zone_pkg::IN_DEP*ZN + i];
         rem_e[i] = r.sync2[conv_zone_pkg::IN_REM*ZN + i] &
            ~r.sync3[conv_zone_pkg::IN_REM*ZN + i];
         clr_e[i] = r.sync2[conv_zone_pkg::IN_CLR*ZN + i] &
            ~r.sync3[conv_zone_pkg::IN_CLR*ZN + i];
         arr_s[i] = r.sync2[conv_zone_pkg::IN_ARR*ZN + i];
         sj_s[i] = r.sync2[conv_zone_pkg::IN_SJAM*ZN + i];
         pin_s[i] = r.sync2[conv_zone_pkg::IN_PIN3*ZN + i];
         accq_s[i] = r.sync2[conv_zone_pkg::IN_ACC*ZN + i];
      end

      // Per-zone logic, downstream zone first so the range chain flows up
      for (int i = 0; i < ZN; i++) begin
         o = r.opt[i];
         // Arrival wait after a discharge
         case (r.ar[i])
            conv_zone_pkg::AR_IDLE: begin
               if (dep_e[i]) begin
                  if (o[conv_zone_pkg::OPT_NO_ARR_TO]) begin
                     n.admit[i] = 1'b1;
                  end else begin
                     n.ar[i] = conv_zone_pkg::AR_WAIT;
                     n.ar_cnt[i] = JAM_LOAD;
                  end
               end
            end
            conv_zone_pkg::AR_WAIT: begin
               if (arr_s[i] || o[conv_zone_pkg::OPT_NO_ARR_TO]) begin
                  n.ar[i] = conv_zone_pkg::AR_IDLE;
                  n.admit[i] = 1'b1;
               end else if (r.ar_cnt[i] == CNT_ZERO) begin
                  n.ar[i] = conv_zone_pkg::AR_JAM;
                  n.arr_jam[i] = 1'b1;
                  ev[i*conv_zone_pkg::EV_W + conv_zone_pkg::EV_ARR] = 1'b1;
                  n.ar_cnt[i] = o[conv_zone_pkg::OPT_SKIP_ARR] ?
                     CNT_ZERO : CLR_LOAD;
               end else begin
                  n.ar_cnt[i] = r.ar_cnt[i] - 1'b1;
               end
            end
            conv_zone_pkg::AR_JAM: begin
               if (arr_s[i] || r.ar_cnt[i] == CNT_ZERO) begin
                  n.ar[i] = conv_zone_pkg::AR_IDLE;
                  n.arr_jam[i] = 1'b0;
                  n.admit[i] = 1'b1;
               end else begin
                  n.ar_cnt[i] = r.ar_cnt[i] - 1'b1;
               end
            end
            default: begin
               n.ar[i] = conv_zone_pkg::AR_IDLE;
               n.arr_jam[i] = 1'b0;
            end
         endcase

         // Sensor jam clearing attempts
         case (r.sj[i])
            conv_zone_pkg::SJ_IDLE: begin
               if (sj_s[i]) begin
                  n.sen_jam[i] = 1'b1;
                  n.att[i] = 2'h0;
                  ev[i*conv_zone_pkg::EV_W + conv_zone_pkg::EV_SEN] = 1'b1;
                  n.sj[i] = o[conv_zone_pkg::OPT_NO_AUTO] ?
                     conv_zone_pkg::SJ_HOLD : conv_zone_pkg::SJ_WAIT;
                  n.sj_cnt[i] = o[conv_zone_pkg::OPT_SKIP_SEN] ?
                     CNT_ZERO : CLR_LOAD;
               end
            end
            conv_zone_pkg::SJ_WAIT: begin
               if (clr_e[i] || r.sj_cnt[i] == CNT_ZERO) begin
                  n.clr_run[i] = 1'b1;
                  if (!sj_s[i]) begin
                     n.sj[i] = conv_zone_pkg::SJ_IDLE;
                     n.sen_jam[i] = 1'b0;
                  end else if (!clr_e[i]) begin
                     n.att[i] = r.att[i] + 1'b1;
                     n.sj_cnt[i] = o[conv_zone_pkg::OPT_SKIP_SEN] ?
                        CNT_ZERO : CLR_LOAD;
                     if (r.att[i] + 1'b1 == conv_zone_pkg::MAX_ATTEMPTS) begin
                        n.sj[i] = conv_zone_pkg::SJ_HOLD;
                        ev[i*conv_zone_pkg::EV_W + conv_zone_pkg::EV_EXH] =
                           1'b1;
                     end
                  end
               end else begin
                  n.sj_cnt[i] = r.sj_cnt[i] - 1'b1;
               end
            end
            conv_zone_pkg::SJ_HOLD: begin
               // Only a cleared sensor ends the hold; a clear request makes one attempt
               if (clr_e[i]) begin
                  n.clr_run[i] = 1'b1;
               end
               if (!sj_s[i]) begin
                  n.sj[i] = conv_zone_pkg::SJ_IDLE;
                  n.sen_jam[i] = 1'b0;
               end
            end
            default: begin
               n.sj[i] = conv_zone_pkg::SJ_IDLE;
               n.sen_jam[i] = 1'b0;
            end
         endcase

         // Lost carton search after a manual removal upstream
         if (rem_e[i] && !o[conv_zone_pkg::OPT_NO_MANUAL]) begin
            n.search[i] = 1'b1;
            ev[i*conv_zone_pkg::EV_W + conv_zone_pkg::EV_SRCH] = 1'b1;
         end

         // Release range chain from control zone to termination zone
         act = o[conv_zone_pkg::OPT_RNG_CTRL] ? pin_s[i] : pass;
         pass = act & ~o[conv_zone_pkg::OPT_RNG_TERM];
         n.train[i] = o[conv_zone_pkg::OPT_DEF_TRAIN] ^ act;

         // Accumulate from request, pin 3 or stored setting
         acc_in = accq_s[i] | (pin_s[i] & ~o[conv_zone_pkg::OPT_RNG_CTRL]);
         n.acc[i] = acc_in | o[conv_zone_pkg::OPT_ACCUM];
      end
      n.range_out = pass;

      // Restore accumulate settings once the strap is synchronised
      if (r.start_cnt != conv_zone_pkg::START_DONE) begin
         n.start_cnt = r.start_cnt + 1'b1;
      end
      if (r.start_cnt == conv_zone_pkg::START_LOAD) begin
         for (int i = 0; i < ZN; i++) begin
            n.opt[i][conv_zone_pkg::OPT_ACCUM] =
               r.sync2[conv_zone_pkg::IN_NVM + i];
         end
      end

      // Wishbone classic slave, answer one cycle after the request
      n.ack = access;
      n.dat = 32'h0000_0000;
      if (access) begin
         case (WB_ADR_I)
            conv_zone_pkg::ADR_OPT_DN,
            conv_zone_pkg::ADR_OPT_UP: begin
               for (int i = 0; i < ZN; i++) begin
                  if (WB_ADR_I[2] == i[0]) begin
                     n.dat[conv_zone_pkg::OPT_W-1:0] = r.opt[i];
                     if (WB_WE_I) begin
                        merged = lane_merge(32'(r.opt[i]), WB_DAT_I,
                           WB_SEL_I);
                        n.opt[i] = merged[conv_zone_pkg::OPT_W-1:0];
                        if (merged[conv_zone_pkg::OPT_ACCUM] !=
                           r.opt[i][conv_zone_pkg::OPT_ACCUM]) begin
                           n.nvm_save = 1'b1;
                        end
                     end
                  end
               end
            end
            conv_zone_pkg::ADR_STATUS: begin
               for (int i = 0; i < ZN; i++) begin
                  n.dat[i*conv_zone_pkg::ST_STRIDE +
                     conv_zone_pkg::ST_ARR_JAM] = r.arr_jam[i];
                  n.dat[i*conv_zone_pkg::ST_STRIDE +
                     conv_zone_pkg::ST_SEN_JAM] = r.sen_jam[i];
                  n.dat[i*conv_zone_pkg::ST_STRIDE +
                     conv_zone_pkg::ST_TRAIN] = r.train[i];
                  n.dat[i*conv_zone_pkg::ST_STRIDE +
                     conv_zone_pkg::ST_ACC] = r.acc[i];
                  n.dat[i*conv_zone_pkg::ST_STRIDE +
                     conv_zone_pkg::ST_ATT +: 2] = r.att[i];
               end
               n.dat[conv_zone_pkg::ST_RNG_OUT] = r.range_out;
            end
            conv_zone_pkg::ADR_IRQ_STAT: begin
               n.dat[IRQ_W-1:0] = r.ist;
               if (WB_WE_I && WB_SEL_I[0]) begin
                  n.ist = r.ist & ~WB_DAT_I[IRQ_W-1:0];
               end
            end
            conv_zone_pkg::ADR_IRQ_MASK: begin
               n.dat[IRQ_W-1:0] = r.imask;
               if (WB_WE_I && WB_SEL_I[0]) begin
                  n.imask = WB_DAT_I[IRQ_W-1:0];
               end
            end
            default: begin
               n.dat = 32'h0000_0000;
            end
         endcase
      end

      // Sticky events win over a same-cycle clear
      n.ist = n.ist | ev;
      n.irq = |(n.ist & n.imask);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         r <= '0;
         for (int i = 0; i < ZN; i++) begin
            r.ar[i] <= conv_zone_pkg::AR_IDLE;
            r.sj[i] <= conv_zone_pkg::SJ_IDLE;
         end
      end else begin
         r <= n;
      end
   end

   // Outputs straight from the state register
   assign WB_ACK_O = r.ack;
   assign WB_DAT_O = r.dat;
   assign ARR_JAM = r.arr_jam;
   assign SEN_JAM = r.sen_jam;
   assign CLEAR_RUN = r.clr_run;
   assign ADMIT = r.admit;
   assign SEARCH = r.search;
   assign TRAIN_MODE = r.train;
   assign ACCUMULATED = r.acc;
   assign RANGE_OUT = r.range_out;
   assign NVM_SAVE = r.nvm_save;
   assign IRQ = r.irq;
   for (genvar g = 0; g < ZN; g++) begin : g_nvm
      assign NVM_DATA[g] = r.opt[g][conv_zone_pkg::OPT_ACCUM];
   end

   // ------------------------------------------------------------
   // Checks per zone, then interrupt level and single-cycle ack
   // ------------------------------------------------------------
   for (genvar g = 0; g < ZN; g++) begin : g_chk
      a_skip_arr_clear: assert property (
         @(posedge CLK_SYS) disable iff (!RST_N)
         $rose(ARR_JAM[g]) && r.opt[g][conv_zone_pkg::OPT_SKIP_ARR]
         |=> !ARR_JAM[g])
         else $error("Arrival jam not cleared at once with skip set");

      a_no_arr_jam: assert property (
         @(posedge CLK_SYS) disable iff (!RST_N)
         $past(r.opt[g][conv_zone_pkg::OPT_NO_ARR_TO]) |-> !$rose(ARR_JAM[g]))
         else $error("Arrival jam raised with timeout disabled");

      a_admit_early: assert property (
         @(posedge CLK_SYS) disable iff (!RST_N)
         r.ar[g] == conv_zone_pkg::AR_IDLE &&
         r.sync2[conv_zone_pkg::IN_DEP*ZN + g] &&
         !r.sync3[conv_zone_pkg::IN_DEP*ZN + g] &&
         r.opt[g][conv_zone_pkg::OPT_NO_ARR_TO] |=> ADMIT[g])
         else $error("Upstream not admitted after departure");

      a_skip_sen_try: assert property (
         @(posedge CLK_SYS) disable iff (!RST_N)
         $rose(SEN_JAM[g]) && r.sj[g] == conv_zone_pkg::SJ_WAIT &&
         r.opt[g][conv_zone_pkg::OPT_SKIP_SEN] |=> CLEAR_RUN[g])
         else $error("No immediate clear attempt with skip set");

      a_hold_quiet: assert property (
         @(posedge CLK_SYS) disable iff (!RST_N)
         r.sj[g] == conv_zone_pkg::SJ_HOLD &&
         !(r.sync2[conv_zone_pkg::IN_CLR*ZN + g] &&
         !r.sync3[conv_zone_pkg::IN_CLR*ZN + g]) |=> !CLEAR_RUN[g])
         else $error("Clear attempt made while holding jam");

      a_hold_jammed: assert property (
         @(posedge CLK_SYS) disable iff (!RST_N)
         r.sj[g] == conv_zone_pkg::SJ_HOLD &&
         r.sync2[conv_zone_pkg::IN_SJAM*ZN + g] |=> SEN_JAM[g])
         else $error("Sensor jam released while sensor blocked");

      a_attempt_cap: assert property (
         @(posedge CLK_SYS) disable iff (!RST_N)
         r.sj[g] == conv_zone_pkg::SJ_WAIT |->
         r.att[g] < conv_zone_pkg::MAX_ATTEMPTS)
         else $error("Too many clear attempts");

      a_search_gate: assert property (
         @(posedge CLK_SYS) disable iff (!RST_N)
         r.opt[g][conv_zone_pkg::OPT_NO_MANUAL] |=> !SEARCH[g])
         else $error("Search run with manual operation disabled");

      a_ctrl_train: assert property (
         @(posedge CLK_SYS) disable iff (!RST_N)
         r.opt[g][conv_zone_pkg::OPT_RNG_CTRL] &&
         $stable(r.opt[g]) |=> TRAIN_MODE[g] ==
         ($past(r.opt[g][conv_zone_pkg::OPT_DEF_TRAIN]) ^
         $past(r.sync2[conv_zone_pkg::IN_PIN3*ZN + g])))
         else $error("Control zone release mode wrong");
   end

   a_irq_level: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      IRQ == |(r.ist & r.imask))
      else $error("Interrupt level mismatch");

   a_ack_single: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      WB_ACK_O |=> !WB_ACK_O)
      else $error("Ack held longer than one cycle");
endmodule

// *** design/conv_zone_pkg.sv ***
// Constants, register map and state types for the conveyor zone options
package conv_zone_pkg;
   // ------------------------------------------------------------
   // Zone count and timing
   // ------------------------------------------------------------
   localparam int ZONES = 2;
   localparam int CLK_MHZ = 25;
   localparam int JAM_TIME_US = 5000;
   localparam int CLEAR_TIME_US = 2000;
   localparam int JAM_CYC_DEF = JAM_TIME_US * CLK_MHZ;
   localparam int CLEAR_CYC_DEF = CLEAR_TIME_US * CLK_MHZ;
   localparam logic [1:0] MAX_ATTEMPTS = 2'h3;
   localparam logic [1:0] START_LOAD = 2'h2;
   localparam logic [1:0] START_DONE = 2'h3;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADR_OPT_DN = 8'h00;
   localparam logic [7:0] ADR_OPT_UP = 8'h04;
   localparam logic [7:0] ADR_STATUS = 8'h08;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h0c;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h10;

   // ------------------------------------------------------------
   // Option flag positions, one word per zone
   // ------------------------------------------------------------
   localparam int OPT_SKIP_ARR = 0;
   localparam int OPT_SKIP_SEN = 1;
   localparam int OPT_NO_AUTO = 2;
   localparam int OPT_NO_ARR_TO = 3;
   localparam int OPT_NO_MANUAL = 4;
   localparam int OPT_RNG_CTRL = 5;
   localparam int OPT_RNG_TERM = 6;
   localparam int OPT_DEF_TRAIN = 7;
   localparam int OPT_ACCUM = 8;
   localparam int OPT_W = 9;

   // ------------------------------------------------------------
   // Status word layout, one byte per zone
   // ------------------------------------------------------------
   localparam int ST_STRIDE = 8;
   localparam int ST_ARR_JAM = 0;
   localparam int ST_SEN_JAM = 1;
   localparam int ST_TRAIN = 2;
   localparam int ST_ACC = 3;
   localparam int ST_ATT = 4;
   localparam int ST_RNG_OUT = 16;

   // ------------------------------------------------------------
   // Interrupt events, four per zone
   // ------------------------------------------------------------
   localparam int EV_ARR = 0;
   localparam int EV_SEN = 1;
   localparam int EV_EXH = 2;
   localparam int EV_SRCH = 3;
   localparam int EV_W = 4;

   // ------------------------------------------------------------
   // Synchroniser vector groups, each ZONES wide except the one-bit range input
   // ------------------------------------------------------------
   localparam int IN_DEP = 0;
   localparam int IN_ARR = 1;
   localparam int IN_SJAM = 2;
   localparam int IN_ACC = 3;
   localparam int IN_PIN3 = 4;
   localparam int IN_REM = 5;
   localparam int IN_CLR = 6;
   localparam int IN_RNG = 14;
   localparam int IN_NVM = 15;
   localparam int SYNC_W = 17;

   // ------------------------------------------------------------
   // One-hot state types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      AR_IDLE = 3'h1,
      AR_WAIT = 3'h2,
      AR_JAM = 3'h4
   } arr_type;

   typedef enum logic [2:0] {
      SJ_IDLE = 3'h1,
      SJ_WAIT = 3'h2,
      SJ_HOLD = 3'h4
   } sj_type;
endpackage

// *** verif/zone_far.sv ***
// Accepting-zone model that reports arrival while told to answer
`timescale 1ns/1ps
module zone_far (
   input wire logic clk,
   input wire logic [1:0] depart,
   input wire logic [1:0] answer,
   output logic [1:0] arrive = 2'h0
);
   // Arrival follows departure one cycle later, only when answering
   always @(posedge clk) begin
      arrive <= answer & depart;
   end
endmodule

// *** verif/conveyor_zone_jam_release_options_tb.sv ***
// Self-checking bench for the conveyor zone option block
`timescale 1ns/1ps
module conveyor_zone_jam_release_options_tb;
   localparam int J = 20;
   localparam int C = 8;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, rng, sv, irq;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0, dat_o, q;
   logic [1:0] dep = 0, sjam = 0, acc = 0, pin3 = 0, rem = 0, clr = 0;
   logic [1:0] answer = 0, arrive, arr_jam, sen_jam, run, admit;
   logic [1:0] search, train, accd, nvd, nvm = 2'h0;
   int miscompares = 0, checks = 0, n_run = 0, n_adm = 0, n_src = 0, b0;
   int n_sv = 0;
   // ------------------------------------------------------------
   // Clock, design and far side
   // ------------------------------------------------------------
   always #20 clk = ~clk;
   conv_zone_opts #(.JAM_CYC(J), .CLEAR_CYC(C)) DUT (
      .CLK_SYS(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wd), .WB_SEL_I(4'hf),
      .WB_ACK_O(ack), .WB_DAT_O(dat_o), .DEPART(dep), .ARRIVE(arrive),
      .SENSOR_JAM(sjam), .ACC_REQ(acc), .PIN3(pin3), .REMOVED(rem),
      .CLEAR_REQ(clr), .RANGE_IN(1'b0), .NVM_ACCUM(nvm),
      .ARR_JAM(arr_jam), .SEN_JAM(sen_jam), .CLEAR_RUN(run),
      .ADMIT(admit), .SEARCH(search), .TRAIN_MODE(train),
      .ACCUMULATED(accd), .RANGE_OUT(rng), .NVM_SAVE(sv),
      .NVM_DATA(nvd), .IRQ(irq));
   zone_far far (.clk(clk), .depart(dep), .answer(answer), .arrive(arrive));
   // Pulse counters of the downstream zone, and of NVM_SAVE for both zones
   always @(posedge clk) begin
      n_run <= n_run + int'(run[0]);
      n_adm <= n_adm + int'(admit[0]);
      n_src <= n_src + int'(search[0]);
      n_sv <= n_sv + int'(sv);
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic go(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle, entered just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(q, e);
   endtask
   task automatic finish_test();
      $display("Checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      go(6000);
      miscompares++;
      finish_test();
   end
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      go(16);
      rst_n <= 1'b1;
      go(6);
      rd(conv_zone_pkg::ADR_OPT_DN, 32'h0);
      rd(conv_zone_pkg::ADR_OPT_UP, 32'h0);
      rd(8'hfc, 32'h0);
      bus(1'b1, conv_zone_pkg::ADR_OPT_DN, 32'hffff);
      check(nvd, 2'h1);
      bus(1'b1, conv_zone_pkg::ADR_OPT_UP, 32'h0a5);
      rd(conv_zone_pkg::ADR_OPT_DN, 32'h1ff);
      rd(conv_zone_pkg::ADR_OPT_UP, 32'h0a5);
      bus(1'b1, conv_zone_pkg::ADR_OPT_UP, 32'h0);
      bus(1'b1, conv_zone_pkg::ADR_OPT_DN, 32'h0);
      check(n_sv, 2);
      $display("Test registers done");
      // Arrival answered, then missed, then skip and timeout options
      answer <= 2'h1;
      b0 = n_adm;
      dep <= 2'h1;
      go(J + 6);
      check(arr_jam, 2'h0);
      check(n_adm - b0, 1);
      dep <= 2'h0;
      answer <= 2'h0;
      go(4);
      dep <= 2'h1;
      go(J + 6);
      check(arr_jam, 2'h1);
      rd(conv_zone_pkg::ADR_IRQ_STAT, 32'h1);
      check(irq, 1'b0);
      bus(1'b1, conv_zone_pkg::ADR_IRQ_MASK, 32'h1);
      check(irq, 1'b1);
      go(C);
      check(arr_jam, 2'h0);
      bus(1'b1, conv_zone_pkg::ADR_IRQ_STAT, 32'h1);
      check(irq, 1'b0);
      dep <= 2'h0;
      bus(1'b1, conv_zone_pkg::ADR_OPT_DN, 32'h1);
      dep <= 2'h1;
      go(J + 6);
      check(arr_jam, 2'h0);
      rd(conv_zone_pkg::ADR_IRQ_STAT, 32'h1);
      dep <= 2'h0;
      bus(1'b1, conv_zone_pkg::ADR_OPT_DN, 32'h8);
      b0 = n_adm;
      dep <= 2'h1;
      go(J + 6);
      check(arr_jam, 2'h0);
      check(n_adm - b0, 1);
      dep <= 2'h0;
      $display("Test arrival done");
      // Sensor jam attempts, external clear, then attempts disabled
      bus(1'b1, conv_zone_pkg::ADR_OPT_DN, 32'h0);
      b0 = n_run;
      sjam <= 2'h1;
      go(4 * C + 20);
      check(n_run - b0, 3);
      check(sen_jam, 2'h1);
      rd(conv_zone_pkg::ADR_STATUS, 32'h32);
      rd(conv_zone_pkg::ADR_IRQ_STAT, 32'h7);
      clr <= 2'h1;
      go(6);
      check(n_run - b0, 4);
      check(sen_jam, 2'h1);
      clr <= 2'h0;
      sjam <= 2'h0;
      go(6);
      check(sen_jam, 2'h0);
      bus(1'b1, conv_zone_pkg::ADR_OPT_DN, 32'h4);
      b0 = n_run;
      sjam <= 2'h1;
      go(4 * C + 20);
      check(n_run - b0, 0);
      check(sen_jam, 2'h1);
      sjam <= 2'h0;
      go(6);
      check(sen_jam, 2'h0);
      bus(1'b1, conv_zone_pkg::ADR_OPT_DN, 32'h2);
      b0 = n_run;
      sjam <= 2'h1;
      go(12);
      check(n_run - b0, 3);
      sjam <= 2'h0;
      go(6);
      $display("Test sensor done");
      // Lost-carton search, then search disabled
      bus(1'b1, conv_zone_pkg::ADR_OPT_DN, 32'h0);
      b0 = n_src;
      rem <= 2'h1;
      go(6);
      check(n_src - b0, 1);
      rem <= 2'h0;
      bus(1'b1, conv_zone_pkg::ADR_OPT_DN, 32'h10);
      rem <= 2'h1;
      go(6);
      check(n_src - b0, 1);
      rem <= 2'h0;
      // Range from control to termination, both default modes
      bus(1'b1, conv_zone_pkg::ADR_OPT_DN, 32'h20);
      bus(1'b1, conv_zone_pkg::ADR_OPT_UP, 32'h40);
      pin3 <= 2'h1;
      go(6);
      check(train, 2'h3);
      check(rng, 1'b0);
      pin3 <= 2'h0;
      go(6);
      check(train, 2'h0);
      bus(1'b1, conv_zone_pkg::ADR_OPT_DN, 32'ha0);
      bus(1'b1, conv_zone_pkg::ADR_OPT_UP, 32'hc0);
      check(train, 2'h3);
      pin3 <= 2'h1;
      go(6);
      check(train, 2'h0);
      pin3 <= 2'h0;
      // Accumulate by request and by local pin
      bus(1'b1, conv_zone_pkg::ADR_OPT_DN, 32'h0);
      bus(1'b1, conv_zone_pkg::ADR_OPT_UP, 32'h0);
      acc <= 2'h2;
      go(6);
      check(accd, 2'h2);
      acc <= 2'h0;
      pin3 <= 2'h1;
      go(6);
      check(accd, 2'h1);
      $display("Test range and accumulate done");
      // Mid-run reset restores the stored accumulate setting
      pin3 <= 2'h0;
      nvm <= 2'h2;
      rst_n <= 1'b0;
      go(2);
      rst_n <= 1'b1;
      go(6);
      check(accd, 2'h2);
      check(nvd, 2'h2);
      rd(conv_zone_pkg::ADR_OPT_UP, 32'h100);
      $display("Test restore done");
      finish_test();
   end
endmodule
